/* ppg_param_rom.sv */
// The register addresses and the APB register port were decided locally.

`include "ppg_map.svh"

module ppg_param_rom #(
  parameter logic [1:0] VARIANT_RST = 2'h0,
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------------------------------
  // Page content lookup
  // ----------------------------------------------------------------
  function automatic logic [7:0] ppg_byte(
    input logic [7:0] off,
    input ppg_pkg::ppg_variant_t v
  );
    logic [7:0] b;
    b = `PPG_VAL_ZERO;
    case (off)
      `PPG_OFF_LUNS: begin
        b = (v == ppg_pkg::PPG_VAR_DUAL_LUN) ? `PPG_VAL_LUN_TWO
                                             : `PPG_VAL_LUN_ONE;
      end
      `PPG_OFF_ADDR_CYC: b = `PPG_VAL_ADDR_CYC;
      `PPG_OFF_BITS_CELL: b = `PPG_VAL_BITS_CELL;
      `PPG_OFF_PROGS: b = `PPG_VAL_PROGS;
      `PPG_OFF_PLANE_ADDR: b = `PPG_VAL_PLANE_ADDR;
      `PPG_OFF_PLANE_ATTR: b = `PPG_VAL_PLANE_ATTR;
      `PPG_OFF_ASYNC_LO: b = `PPG_VAL_MASK_MODE5;
      `PPG_OFF_ASYNC_HI: b = `PPG_VAL_ZERO;
      `PPG_OFF_SYNC_LO: begin
        case (v)
          ppg_pkg::PPG_VAR_ASYNC_ONLY: b = `PPG_VAL_ZERO;
          ppg_pkg::PPG_VAR_SYNC_MODE4: b = `PPG_VAL_MASK_MODE4;
          default: b = `PPG_VAL_MASK_MODE5;
        endcase
      end
      `PPG_OFF_SYNC_HI: b = `PPG_VAL_ZERO;
      `PPG_OFF_ASYNC_FEAT: b = `PPG_VAL_ASYNC_FEAT;
      // Reserved ranges and offsets outside the slice read as zero
      default: b = `PPG_VAL_ZERO;
    endcase
    return b;
  endfunction : ppg_byte

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  ppg_pkg::ppg_variant_t variant_ff;
  ppg_pkg::ppg_variant_t nxt_variant;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic acc;
  logic done;
  logic hit;
  logic in_range;
  logic data_rd_done;
  logic [7:0] cur_byte;

  assign acc = psel & penable;
  // One wait state so that read data comes from a flip-flop
  assign done = acc & pready_ff;
  assign hit = (paddr == `PPG_REG_CTRL) || (paddr == `PPG_REG_PTR) ||
               (paddr == `PPG_REG_DATA) || (paddr == `PPG_REG_STATUS);
  assign in_range = (ptr_ff >= `PPG_OFF_FIRST) && (ptr_ff <= `PPG_OFF_LAST);
  assign data_rd_done = done & ~pwrite & (paddr == `PPG_REG_DATA);
  assign cur_byte = ppg_byte(ptr_ff, variant_ff);

  always_comb begin
    nxt_variant = variant_ff;
    nxt_ptr = ptr_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = acc & ~pready_ff;
    nxt_pslverr = acc & ~pready_ff & ~hit;
    if (acc && !pready_ff) begin
      nxt_prdata = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          `PPG_REG_CTRL: begin
            nxt_prdata[`PPG_CTRL_VAR_MSB:`PPG_CTRL_VAR_LSB] = variant_ff;
          end
          `PPG_REG_PTR: nxt_prdata[7:0] = ptr_ff;
          `PPG_REG_DATA: nxt_prdata[7:0] = cur_byte;
          `PPG_REG_STATUS: begin
            nxt_prdata[`PPG_STATUS_INRANGE_BIT] = in_range;
          end
          default: nxt_prdata = 32'h0000_0000;
        endcase
      end
    end
    if (done && pwrite) begin
      case (paddr)
        `PPG_REG_CTRL: begin
          nxt_variant = ppg_pkg::ppg_variant_t'(
            pwdata[`PPG_CTRL_VAR_MSB:`PPG_CTRL_VAR_LSB]);
        end
        `PPG_REG_PTR: nxt_ptr = pwdata[7:0];
        default: nxt_ptr = ptr_ff;
      endcase
    end
    // Each data read advances to the next offset, so a plain burst of
    // reads walks multi-byte fields low byte first
    if (data_rd_done) begin
      nxt_ptr = ptr_ff + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      variant_ff <= ppg_pkg::ppg_variant_t'(VARIANT_RST);
      ptr_ff <= `PPG_PTR_RST;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      variant_ff <= nxt_variant;
      ptr_ff <= nxt_ptr;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ----------------------------------------------------------------
  // Checker state: last data byte handed out and its offset
  // ----------------------------------------------------------------
  // Only the assertions and the c_pair cover read these, so they cost nothing once trimmed
  logic [7:0] chk_off_ff;
  logic [7:0] nxt_chk_off;
  logic [7:0] chk_byte_ff;
  logic [7:0] nxt_chk_byte;

  always_comb begin
    nxt_chk_off = chk_off_ff;
    nxt_chk_byte = chk_byte_ff;
    if (data_rd_done) begin
      nxt_chk_off = ptr_ff;
      nxt_chk_byte = prdata_ff[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chk_off_ff <= `PPG_VAL_ZERO;
      chk_byte_ff <= `PPG_VAL_ZERO;
    end else begin
      chk_off_ff <= nxt_chk_off;
      chk_byte_ff <= nxt_chk_byte;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_luns;
    data_rd_done && ptr_ff == `PPG_OFF_LUNS |->
      prdata[7:0] == ((variant_ff == ppg_pkg::PPG_VAR_DUAL_LUN) ?
                      8'h02 : 8'h01);
  endproperty
  a_luns: assert property (p_luns) else $error("LUN count wrong");

  property p_addr_cyc;
    data_rd_done && ptr_ff == `PPG_OFF_ADDR_CYC |->
      prdata[7:4] == 4'h2 && prdata[3:0] == 4'h3;
  endproperty
  a_addr_cyc: assert property (p_addr_cyc)
    else $error("Address cycle byte wrong");

  property p_cell_prog;
    data_rd_done && (ptr_ff == `PPG_OFF_BITS_CELL ||
                     ptr_ff == `PPG_OFF_PROGS) |->
      prdata[7:0] == ((ptr_ff == `PPG_OFF_BITS_CELL) ? 8'h02 : 8'h01);
  endproperty
  a_cell_prog: assert property (p_cell_prog)
    else $error("Cell or program count wrong");

  property p_plane;
    data_rd_done && ptr_ff == `PPG_OFF_PLANE_ADDR |->
      prdata[7:4] == 4'h0 && prdata[3:0] == 4'h1;
  endproperty
  a_plane: assert property (p_plane)
    else $error("Plane address byte wrong");

  property p_plane_attr;
    data_rd_done && ptr_ff == `PPG_OFF_PLANE_ATTR |->
      prdata[2:0] == 3'h7 && prdata[7:3] == 5'h00;
  endproperty
  a_plane_attr: assert property (p_plane_attr)
    else $error("Plane attribute byte wrong");

  property p_async_pair;
    data_rd_done && ptr_ff == `PPG_OFF_ASYNC_HI &&
      chk_off_ff == `PPG_OFF_ASYNC_LO |->
      prdata[7:0] == 8'h00 && chk_byte_ff == 8'h3F;
  endproperty
  a_async_pair: assert property (p_async_pair)
    else $error("Async mask not low byte first");

  property p_mode0;
    data_rd_done && (ptr_ff == `PPG_OFF_ASYNC_LO ||
                     ptr_ff == `PPG_OFF_SYNC_LO) && prdata[7:0] != 8'h00
      |-> prdata[0];
  endproperty
  a_mode0: assert property (p_mode0)
    else $error("Mode 0 bit clear in mask");

  property p_sync;
    data_rd_done && ptr_ff == `PPG_OFF_SYNC_LO |->
      prdata[7:0] == ((variant_ff == ppg_pkg::PPG_VAR_ASYNC_ONLY) ? 8'h00 :
                      (variant_ff == ppg_pkg::PPG_VAR_SYNC_MODE4) ? 8'h1F :
                      8'h3F);
  endproperty
  a_sync: assert property (p_sync) else $error("Sync mask wrong");

  property p_feat;
    data_rd_done && (ptr_ff == `PPG_OFF_ASYNC_FEAT ||
                     ptr_ff == `PPG_OFF_SYNC_HI) |-> prdata[7:0] == 8'h00;
  endproperty
  a_feat: assert property (p_feat) else $error("Feature byte nonzero");

  property p_rsvd;
    data_rd_done && ((ptr_ff >= `PPG_OFF_RSVD_A_LO &&
                      ptr_ff <= `PPG_OFF_RSVD_A_HI) ||
                     ptr_ff == `PPG_OFF_RSVD_B_LO ||
                     ptr_ff == `PPG_OFF_RSVD_B_HI) |-> prdata == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("Reserved byte nonzero");

  property p_advance;
    data_rd_done |=> ptr_ff == $past(ptr_ff) + 8'h01;
  endproperty
  a_advance: assert property (p_advance)
    else $error("Pointer did not advance");

  property p_answer;
    psel && !penable ##1 acc |-> ##1 pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("APB answer timing");

  property p_sync_pair;
    data_rd_done && ptr_ff == `PPG_OFF_SYNC_HI &&
      chk_off_ff == `PPG_OFF_SYNC_LO |->
      prdata[7:0] == 8'h00 &&
      chk_byte_ff == ((variant_ff == ppg_pkg::PPG_VAR_ASYNC_ONLY) ? 8'h00 :
                      (variant_ff == ppg_pkg::PPG_VAR_SYNC_MODE4) ? 8'h1F :
                      8'h3F);
  endproperty
  a_sync_pair: assert property (p_sync_pair)
    else $error("Sync mask not low byte first");

  // Unmapped place: error flagged with the answer, no data returned
  property p_err;
    acc && !pready_ff && !hit |=> pready && pslverr && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("Unmapped access not refused");

  property p_quiet;
    !acc |=> !pready && !pslverr;
  endproperty
  a_quiet: assert property (p_quiet) else $error("Answer without access");

  property p_ptr_hold;
    !data_rd_done && !(done && pwrite && paddr == `PPG_REG_PTR) |=>
      $stable(ptr_ff);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("Pointer moved without access");

  property p_ctrl_wr;
    done && pwrite && paddr == `PPG_REG_CTRL |=>
      variant_ff == $past(pwdata[`PPG_CTRL_VAR_MSB:`PPG_CTRL_VAR_LSB]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("Variant write lost");

  c_dual: cover property (data_rd_done && ptr_ff == `PPG_OFF_LUNS &&
                          prdata[7:0] == 8'h02);
  c_mode4: cover property (data_rd_done && prdata[7:0] == 8'h1F);
  c_err: cover property (pready && pslverr);
  c_walk: cover property (data_rd_done && ptr_ff == `PPG_OFF_LAST);
  c_pair: cover property (data_rd_done && ptr_ff == `PPG_OFF_ASYNC_HI &&
                          chk_off_ff == `PPG_OFF_ASYNC_LO);

endmodule : ppg_param_rom

/* ppg_map.svh */
`ifndef PPG_MAP_SVH
`define PPG_MAP_SVH

// ----------------------------------------------------------------
// APB register byte addresses
// ----------------------------------------------------------------
`define PPG_REG_CTRL 12'h000
`define PPG_REG_PTR 12'h004
`define PPG_REG_DATA 12'h008
`define PPG_REG_STATUS 12'h00C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PPG_CTRL_VAR_MSB 1
`define PPG_CTRL_VAR_LSB 0
`define PPG_STATUS_INRANGE_BIT 0
`define PPG_PTR_RST 8'h64

// ----------------------------------------------------------------
// Parameter page offsets of this slice
// ----------------------------------------------------------------
`define PPG_OFF_FIRST 8'h64
`define PPG_OFF_LUNS 8'h64
`define PPG_OFF_ADDR_CYC 8'h65
`define PPG_OFF_BITS_CELL 8'h66
`define PPG_OFF_PROGS 8'h67
`define PPG_OFF_PLANE_ADDR 8'h68
`define PPG_OFF_PLANE_ATTR 8'h69
`define PPG_OFF_RSVD_A_LO 8'h6A
`define PPG_OFF_RSVD_A_HI 8'h8F
`define PPG_OFF_ASYNC_LO 8'h90
`define PPG_OFF_ASYNC_HI 8'h91
`define PPG_OFF_RSVD_B_LO 8'h92
`define PPG_OFF_RSVD_B_HI 8'h93
`define PPG_OFF_SYNC_LO 8'h94
`define PPG_OFF_SYNC_HI 8'h95
`define PPG_OFF_ASYNC_FEAT 8'h96
`define PPG_OFF_LAST 8'h96

// ----------------------------------------------------------------
// Page byte values
// ----------------------------------------------------------------
`define PPG_VAL_ZERO 8'h00
`define PPG_VAL_LUN_ONE 8'h01
`define PPG_VAL_LUN_TWO 8'h02
`define PPG_VAL_ADDR_CYC 8'h23
`define PPG_VAL_BITS_CELL 8'h02
`define PPG_VAL_PROGS 8'h01
`define PPG_VAL_PLANE_ADDR 8'h01
`define PPG_VAL_PLANE_ATTR 8'h07
`define PPG_VAL_MASK_MODE4 8'h1F
`define PPG_VAL_MASK_MODE5 8'h3F
`define PPG_VAL_ASYNC_FEAT 8'h00

`endif

/* ppg_pkg.sv */
package ppg_pkg;

  // Device variant: selects the variant-dependent page bytes
  typedef enum logic [1:0] {
    PPG_VAR_ASYNC_ONLY = 2'b00,
    PPG_VAR_SYNC_MODE4 = 2'b01,
    PPG_VAR_SYNC_MODE5 = 2'b10,
    PPG_VAR_DUAL_LUN = 2'b11
  } ppg_variant_t;

endpackage : ppg_pkg

/* ppg_host_model.sv */
// ----------------------------------------------------------------
// Register bus master standing in for the page-reading host
// ----------------------------------------------------------------
module ppg_host_model (
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // One full transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show no stale value, so a late sample cannot pass
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : ppg_host_model

/* test_ppg_param_rom.sv */
`include "ppg_map.svh"

module test_ppg_param_rom;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int error_cnt = 0;
  int comparisons = 0;

  always #4 clk = ~clk;

  ppg_host_model host (.clk(clk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  ppg_param_rom #(.VARIANT_RST(2'h0), .ADDR_W(12)) DUT (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // ----------------------------------------------------------------
  // Expected page content per variant
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_byte(input logic [7:0] off,
                                          input logic [1:0] v);
    case (off)
      8'h64: exp_byte = (v == 2'h3) ? 8'h02 : 8'h01;
      8'h65: exp_byte = 8'h23;
      8'h66: exp_byte = 8'h02;
      8'h67, 8'h68: exp_byte = 8'h01;
      8'h69: exp_byte = 8'h07;
      8'h90: exp_byte = 8'h3F;
      8'h94: exp_byte = (v == 2'h0) ? 8'h00 : (v == 2'h1) ? 8'h1F : 8'h3F;
      default: exp_byte = 8'h00;
    endcase
  endfunction : exp_byte

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] rd;
    logic err;
    host.xfer(1'b0, a, 32'h0000_0000, rd, err);
    chk(rd, exp, "read data");
    chk({31'h0, err}, {31'h0, exp_err}, "error response");
  endtask : rd_chk

  // One page byte through the data window, against the expected table
  task automatic rd_page(input int v, input int off);
    rd_chk(`PPG_REG_DATA, {24'h0, exp_byte(8'(off), 2'(v))}, 1'b0);
  endtask : rd_page

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    host.xfer(1'b1, a, d, rd, err);
    chk({31'h0, err}, 32'h0000_0000, "write response");
  endtask : wr

  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`PPG_REG_CTRL, 32'h0000_0000, 1'b0);
    rd_chk(`PPG_REG_PTR, 32'h0000_0064, 1'b0);
    rd_chk(`PPG_REG_STATUS, 32'h0000_0001, 1'b0);
    $display("test reset_values done");
    // Every variant, whole slice read in order, one idle cycle between transfers
    for (int v = 0; v < 4; v++) begin
      wr(`PPG_REG_CTRL, 32'(v));
      wr(`PPG_REG_PTR, 32'h0000_0064);
      rd_chk(`PPG_REG_CTRL, 32'(v), 1'b0);
      for (int off = 100; off <= 150; off++) begin
        rd_page(v, off);
      end
      rd_chk(`PPG_REG_PTR, 32'h0000_0097, 1'b0);
      rd_chk(`PPG_REG_STATUS, 32'h0000_0000, 1'b0);
      $display("test variant %0d done", v);
    end
    // Unmapped place, ignored write, pointer wrap
    rd_chk(12'h010, 32'h0000_0000, 1'b1);
    wr(`PPG_REG_PTR, 32'h0000_00FF);
    wr(`PPG_REG_DATA, 32'h0000_0055);
    rd_chk(`PPG_REG_PTR, 32'h0000_00FF, 1'b0);
    rd_chk(`PPG_REG_DATA, 32'h0000_0000, 1'b0);
    rd_chk(`PPG_REG_PTR, 32'h0000_0000, 1'b0);
    $display("test refusals done");
    // Reset in mid-run brings variant and pointer back
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`PPG_REG_CTRL, 32'h0000_0000, 1'b0);
    rd_chk(`PPG_REG_PTR, 32'h0000_0064, 1'b0);
    $display("test mid_reset done");
    test_done();
  end

  // Whole run needs about 1000 cycles; cut a hang well past that
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end
endmodule : test_ppg_param_rom
